//--- scr_defs.vh
// Behaviour
// - mode 01 senses the line continuously and wakes on broadcast detection.
// - mode 10 senses every 32 ms; no broadcast means back to sleep.
// - mode 11 never senses and shuts analog resources down.
// - deep sleep exits only on sleep-request rise or command-select toggle.
// - sleep-request rise in sleep raises inhibit; sends broadcast if automatic enabled.
// - wake-busy stays high for the whole broadcast transmission.
// - host data output rises again when broadcast transmission completes.
// - broadcast detected while sensing raises inhibit, standby, busy during reception.
// - standby goes to normal when the host raises sleep-request.
// - enter-sleep bit via command mode enters selected sleep, inhibit low.
// - command-select toggle exits sleep without broadcast; normal if request high.
// - control 1 bit 0 selects 66 mA when set, 33 mA clear; reset 0.
// - control 1 bit 3 selects 2 Vpp when set, 1 Vpp clear; reset 1.
// - carrier select is 8-bit read/write, reset selects 13 MHz.
// - sleep mode field resets to 00, enhanced periodic sleep.
// - sleep control bit 2 picks long broadcast duration; reset 1.
// - sleep control bit 3 at 0 suppresses broadcast after request wake.
// - writing bit 7 starts sleep; cleared once sleep is entered.
// - sleep control bits 4, 5, 6 read fixed 0, 1, 0.
// - 10-bit almost-full threshold from threshold low and high bits 1:0; 256.
// - threshold high bit 5 is read-only overflow; bits 7:6, 4:2 zero.
// - all registers take defaults on reset; host reads them and writes all but the ID registers.
// - broadcast lasts 250 us/75 ms short, 1.5 ms/150 ms long.
// - write frame id 0x555, length 3, bytes 0xf5, address, data.
// - read frame id 0x555, length 2, 0xfd, address; reply id 0, length 1.
// - command mode holds soft reset, clears receive FIFO, no line traffic.
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH
// ***************
// register map
// ***************
`define SCR_ADDR_TXL 8'h01
`define SCR_ADDR_CAR 8'h02
`define SCR_ADDR_SLC 8'h03
`define SCR_ADDR_THL 8'h05
`define SCR_ADDR_THH 8'h06
`define SCR_ADDR_ID5 8'h59
`define SCR_ADDR_ID4 8'h5a
`define SCR_ADDR_ID3 8'h5b
`define SCR_ADDR_ID2 8'h5c
`define SCR_ADDR_ID1 8'h5d
`define SCR_ADDR_ID0 8'h5e
`define SCR_TXL_DRV 0
`define SCR_TXL_LVL 3
`define SCR_SLC_LONG 2
`define SCR_SLC_AUTO 3
`define SCR_SLC_GO 7
`define SCR_TXL_FIX 4'hf
`define SCR_SLC_FIX 3'h2
`define SCR_RST_DRV 1'b0
`define SCR_RST_LVL 1'b1
`define SCR_RST_CAR 8'h50
`define SCR_RST_MODE 2'h0
`define SCR_RST_LONG 1'b1
`define SCR_RST_AUTO 1'b1
`define SCR_RST_THR 10'h100
`define SCR_MODE_FAST 2'h1
`define SCR_MODE_DEEP 2'h3
// ***************
// command frames
// ***************
`define SCR_CMD_ID 11'h555
`define SCR_WR_OP 8'hf5
`define SCR_RD_OP 8'hfd
`define SCR_WR_DLC 4'h3
`define SCR_RD_DLC 4'h2
`define SCR_RPL_ID 11'h000
`define SCR_RPL_DLC 4'h1
// ***************
// timing
// ***************
`define SCR_CLK_KHZ 100000
`define SCR_T_PERIOD_MS 32
`define SCR_T_SENSE_US 1000
`define SCR_T_WF_SHORT_US 250
`define SCR_T_WF_LONG_US 1500
`define SCR_T_WP_SHORT_MS 75
`define SCR_T_WP_LONG_MS 150
`endif

//--- scr_sleep_ctrl.v
`timescale 1ns/1ps
`include "scr_defs.vh"
module scr_sleep_ctrl #(
  parameter [31:0] PERIOD_CYC = `SCR_T_PERIOD_MS * `SCR_CLK_KHZ,
  parameter [31:0] SENSE_CYC = `SCR_T_SENSE_US * `SCR_CLK_KHZ / 1000,
  parameter [31:0] WF_SHORT_CYC = `SCR_T_WF_SHORT_US * `SCR_CLK_KHZ / 1000,
  parameter [31:0] WF_LONG_CYC = `SCR_T_WF_LONG_US * `SCR_CLK_KHZ / 1000,
  parameter [31:0] WP_SHORT_CYC = `SCR_T_WP_SHORT_MS * `SCR_CLK_KHZ,
  parameter [31:0] WP_LONG_CYC = `SCR_T_WP_LONG_MS * `SCR_CLK_KHZ,
  parameter [47:0] UNIQUE_DEVICE_ID = 48'h0123456789ab // arbitrary value
)(
  input wire i_clk,
  input wire i_srst,
  input wire i_sleep_request_n,
  input wire i_host_command_select,
  input wire i_wake_detect,
  input wire i_wake_rx_active,
  input wire i_rx_byte_valid,
  input wire i_rx_fifo_full,
  input wire i_frame_valid,
  input wire [10:0] i_frame_id,
  input wire [3:0] i_frame_dlc,
  input wire [7:0] i_frame_b0,
  input wire [7:0] i_frame_b1,
  input wire [7:0] i_frame_b2,
  output wire o_inhibit_out,
  output wire o_wake_busy,
  output wire o_host_data_out,
  output wire o_wake_tx_en,
  output wire o_sense_en,
  output wire o_analog_en,
  output wire o_soft_reset,
  output wire o_rx_fifo_clear,
  output wire o_tx_high_drive,
  output wire o_tx_level_2vpp,
  output wire [7:0] o_carrier_sel,
  output wire [9:0] o_rx_almost_full_thr,
  output wire o_rx_overflow,
  output wire o_reply_valid,
  output wire [10:0] o_reply_id,
  output wire [3:0] o_reply_dlc,
  output wire [7:0] o_reply_data
);
  localparam [1:0] ST_NORMAL = 2'h0;
  localparam [1:0] ST_SLEEP = 2'h1;
  localparam [1:0] ST_SENSE = 2'h2;
  localparam [1:0] ST_STANDBY = 2'h3;
  // a literal cannot be part-selected, so the default lives in a named constant
  localparam [9:0] RST_THR = `SCR_RST_THR;

  // ***************
  // pin synchronisers
  // ***************
  reg nsl_s1_reg, nsl_s2_reg, nsl_s3_reg;
  reg hdc_s1_reg, hdc_s2_reg, hdc_s3_reg;
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      nsl_s1_reg <= 1'b1;
      nsl_s2_reg <= 1'b1;
      nsl_s3_reg <= 1'b1;
      hdc_s1_reg <= 1'b1;
      hdc_s2_reg <= 1'b1;
      hdc_s3_reg <= 1'b1;
    end
    else
    begin
      nsl_s1_reg <= i_sleep_request_n;
      nsl_s2_reg <= nsl_s1_reg;
      nsl_s3_reg <= nsl_s2_reg;
      hdc_s1_reg <= i_host_command_select;
      hdc_s2_reg <= hdc_s1_reg;
      hdc_s3_reg <= hdc_s2_reg;
    end
  end
  wire nsl_rise = nsl_s2_reg & ~nsl_s3_reg;
  wire nsl_fall = ~nsl_s2_reg & nsl_s3_reg;
  wire hdc_rise = hdc_s2_reg & ~hdc_s3_reg;
  wire hdc_fall = ~hdc_s2_reg & hdc_s3_reg;

  // ***************
  // registers and command frames
  // ***************
  reg [1:0] state_reg, state_next;
  reg drv_reg, lvl_reg, long_reg, auto_reg, go_reg, ovf_reg;
  reg [7:0] car_reg, thl_reg;
  reg [1:0] mode_reg, thh_reg;
  reg rpl_valid_reg;
  reg [10:0] rpl_id_reg;
  reg [3:0] rpl_dlc_reg;
  reg [7:0] rpl_data_reg, rd_data;
  wire asleep = (state_reg == ST_SLEEP) | (state_reg == ST_SENSE);
  // frames only count while the chip is awake and held in command mode
  wire cmd_mode = (state_reg == ST_NORMAL) & ~hdc_s2_reg;
  wire cmd_frame = i_frame_valid & cmd_mode & (i_frame_id == `SCR_CMD_ID);
  wire wr_hit = cmd_frame & (i_frame_dlc == `SCR_WR_DLC)
    & (i_frame_b0 == `SCR_WR_OP);
  wire rd_hit = cmd_frame & (i_frame_dlc == `SCR_RD_DLC)
    & (i_frame_b0 == `SCR_RD_OP);

  always @*
  begin
    case (i_frame_b1)
      `SCR_ADDR_TXL: rd_data = {`SCR_TXL_FIX, lvl_reg, 2'h0, drv_reg};
      `SCR_ADDR_CAR: rd_data = car_reg;
      // go bit is write-only and reads zero
      `SCR_ADDR_SLC: rd_data = {1'b0, `SCR_SLC_FIX, auto_reg, long_reg, mode_reg};
      `SCR_ADDR_THL: rd_data = thl_reg;
      `SCR_ADDR_THH: rd_data = {2'h0, ovf_reg, 3'h0, thh_reg};
      `SCR_ADDR_ID5: rd_data = UNIQUE_DEVICE_ID[47:40];
      `SCR_ADDR_ID4: rd_data = UNIQUE_DEVICE_ID[39:32];
      `SCR_ADDR_ID3: rd_data = UNIQUE_DEVICE_ID[31:24];
      `SCR_ADDR_ID2: rd_data = UNIQUE_DEVICE_ID[23:16];
      `SCR_ADDR_ID1: rd_data = UNIQUE_DEVICE_ID[15:8];
      `SCR_ADDR_ID0: rd_data = UNIQUE_DEVICE_ID[7:0];
      default: rd_data = 8'h00;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      drv_reg <= `SCR_RST_DRV;
      lvl_reg <= `SCR_RST_LVL;
      car_reg <= `SCR_RST_CAR;
      mode_reg <= `SCR_RST_MODE;
      long_reg <= `SCR_RST_LONG;
      auto_reg <= `SCR_RST_AUTO;
      go_reg <= 1'b0;
      thl_reg <= RST_THR[7:0];
      thh_reg <= RST_THR[9:8];
      ovf_reg <= 1'b0;
      rpl_valid_reg <= 1'b0;
      rpl_id_reg <= `SCR_RPL_ID;
      rpl_dlc_reg <= `SCR_RPL_DLC;
      rpl_data_reg <= 8'h00;
    end
    else
    begin
      if (wr_hit)
      begin
        case (i_frame_b1)
          `SCR_ADDR_TXL:
          begin
            drv_reg <= i_frame_b2[`SCR_TXL_DRV];
            lvl_reg <= i_frame_b2[`SCR_TXL_LVL];
          end
          `SCR_ADDR_CAR: car_reg <= i_frame_b2;
          `SCR_ADDR_SLC:
          begin
            mode_reg <= i_frame_b2[1:0];
            long_reg <= i_frame_b2[`SCR_SLC_LONG];
            auto_reg <= i_frame_b2[`SCR_SLC_AUTO];
          end
          `SCR_ADDR_THL: thl_reg <= i_frame_b2;
          `SCR_ADDR_THH: thh_reg <= i_frame_b2[1:0];
          default: ;
        endcase
      end
      // a fresh write of the go bit wins over the self-clear
      if (wr_hit & (i_frame_b1 == `SCR_ADDR_SLC) & i_frame_b2[`SCR_SLC_GO])
        go_reg <= 1'b1;
      else if (asleep)
        go_reg <= 1'b0;
      if (i_rx_byte_valid & i_rx_fifo_full)
        ovf_reg <= 1'b1;
      else if (cmd_mode)
        ovf_reg <= 1'b0;
      rpl_valid_reg <= rd_hit;
      if (rd_hit)
        rpl_data_reg <= rd_data;
    end
  end

  // ***************
  // sleep sequencer
  // ***************
  reg [31:0] slp_cnt_reg, wk_cnt_reg, wk_len;
  reg hdc_low_reg, tx_on_reg, rx_busy_reg, sense_reg;
  reg inh_reg, busy_reg, hdo_reg, analog_reg, soft_reg, fclr_reg;
  wire periodic = ~mode_reg[0];
  wire det = asleep & sense_reg & i_wake_detect;
  // a toggle needs a fall seen while asleep, so the release of command
  // mode right after the go write is not taken as a wake
  wire hdc_toggle = asleep & hdc_low_reg & hdc_rise;
  wire wake_start = asleep & nsl_rise & auto_reg;
  wire per_done = (state_reg == ST_SLEEP) & periodic
    & (mode_reg != `SCR_MODE_DEEP) & (slp_cnt_reg == PERIOD_CYC - 32'h1);
  wire sns_done = (state_reg == ST_SENSE) & (slp_cnt_reg == SENSE_CYC - 32'h1);

  always @*
  begin
    if (mode_reg == `SCR_MODE_FAST)
      wk_len = long_reg ? WF_LONG_CYC : WF_SHORT_CYC;
    else
      wk_len = long_reg ? WP_LONG_CYC : WP_SHORT_CYC;
  end

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_NORMAL:
        if (nsl_fall | go_reg)
          state_next = ST_SLEEP;
      ST_SLEEP, ST_SENSE:
        if (nsl_rise)
          state_next = ST_NORMAL;
        else if (hdc_toggle | det)
          state_next = nsl_s2_reg ? ST_NORMAL : ST_STANDBY;
        else if (per_done)
          state_next = ST_SENSE;
        else if (sns_done)
          state_next = ST_SLEEP;
      ST_STANDBY:
        if (nsl_s2_reg)
          state_next = ST_NORMAL;
      default: state_next = ST_NORMAL;
    endcase
  end

  wire sleep_next = (state_next == ST_SLEEP) | (state_next == ST_SENSE);
  wire tx_on_next = wake_start | (tx_on_reg & (wk_cnt_reg != 32'h0));
  wire rx_busy_next = det | (rx_busy_reg & i_wake_rx_active);
  wire cmd_next = (state_next == ST_NORMAL) & ~hdc_s2_reg;

  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_reg <= ST_NORMAL;
      slp_cnt_reg <= 32'h0;
      wk_cnt_reg <= 32'h0;
      hdc_low_reg <= 1'b0;
      tx_on_reg <= 1'b0;
      rx_busy_reg <= 1'b0;
      sense_reg <= 1'b0;
      inh_reg <= 1'b1;
      busy_reg <= 1'b0;
      hdo_reg <= 1'b1;
      analog_reg <= 1'b1;
      soft_reg <= 1'b0;
      fclr_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_next != state_reg)
        slp_cnt_reg <= 32'h0;
      else
        slp_cnt_reg <= slp_cnt_reg + 32'h1;
      if (!asleep)
        hdc_low_reg <= 1'b0;
      else if (hdc_fall)
        hdc_low_reg <= 1'b1;
      if (wake_start)
        wk_cnt_reg <= wk_len - 32'h1;
      else if (tx_on_reg & (wk_cnt_reg != 32'h0))
        wk_cnt_reg <= wk_cnt_reg - 32'h1;
      tx_on_reg <= tx_on_next;
      rx_busy_reg <= rx_busy_next;
      // fast mode listens all through sleep, periodic only in windows
      sense_reg <= sleep_next & ((mode_reg == `SCR_MODE_FAST)
        | (state_next == ST_SENSE));
      inh_reg <= ~sleep_next;
      busy_reg <= tx_on_next | rx_busy_next;
      // low through sleep and the broadcast, so its rise marks completion
      hdo_reg <= ~(sleep_next | tx_on_next);
      analog_reg <= ~(sleep_next & (mode_reg == `SCR_MODE_DEEP));
      soft_reg <= (state_next != ST_NORMAL) | cmd_next;
      fclr_reg <= cmd_next;
    end
  end

  assign o_inhibit_out = inh_reg;
  assign o_wake_busy = busy_reg;
  assign o_host_data_out = hdo_reg;
  assign o_wake_tx_en = tx_on_reg;
  assign o_sense_en = sense_reg;
  assign o_analog_en = analog_reg;
  assign o_soft_reset = soft_reg;
  assign o_rx_fifo_clear = fclr_reg;
  assign o_tx_high_drive = drv_reg;
  assign o_tx_level_2vpp = lvl_reg;
  assign o_carrier_sel = car_reg;
  assign o_rx_almost_full_thr = {thh_reg, thl_reg};
  assign o_rx_overflow = ovf_reg;
  assign o_reply_valid = rpl_valid_reg;
  assign o_reply_id = rpl_id_reg;
  assign o_reply_dlc = rpl_dlc_reg;
  assign o_reply_data = rpl_data_reg;
endmodule // scr_sleep_ctrl

//--- scr_sleep_ctrl_properties.sv
`timescale 1ns/1ps
// ***************
// checker
// ***************
module scr_sleep_ctrl_chk (
  input wire i_clk,
  input wire i_srst,
  input wire i_rx_byte_valid,
  input wire i_rx_fifo_full,
  input wire i_frame_valid,
  input wire [7:0] i_frame_b0,
  input wire o_inhibit_out,
  input wire o_wake_busy,
  input wire o_host_data_out,
  input wire o_wake_tx_en,
  input wire o_sense_en,
  input wire o_analog_en,
  input wire o_soft_reset,
  input wire o_rx_fifo_clear,
  input wire o_rx_overflow,
  input wire o_reply_valid,
  input wire [10:0] o_reply_id,
  input wire [3:0] o_reply_dlc
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  reply_hdr_a: assert property (o_reply_valid
    |-> o_reply_id == 11'h000 && o_reply_dlc == 4'h1)
    else $error("reply header wrong");
  reply_cause_a: assert property (o_reply_valid
    |-> $past(i_frame_valid && i_frame_b0 == 8'hfd))
    else $error("reply without frame");
  tx_len_a: assert property ($rose(o_wake_tx_en) |-> o_wake_tx_en [*8])
    else $error("broadcast too short");
  tx_busy_a: assert property (o_wake_tx_en |-> o_wake_busy && !o_host_data_out)
    else $error("busy low in broadcast");
  tx_done_a: assert property ($fell(o_wake_tx_en) |-> o_host_data_out)
    else $error("host data not back");
  sleep_out_a: assert property (!o_inhibit_out |-> o_soft_reset && !o_host_data_out)
    else $error("sleep outputs wrong");
  deep_off_a: assert property (!o_analog_en |-> !o_sense_en && !o_inhibit_out)
    else $error("analog off outside deep");
  ovf_set_a: assert property (i_rx_byte_valid && i_rx_fifo_full |=> o_rx_overflow)
    else $error("overflow not set");
  cmd_clr_a: assert property (o_rx_fifo_clear |-> o_soft_reset)
    else $error("clear without soft reset");
endmodule // scr_sleep_ctrl_chk

bind scr_sleep_ctrl scr_sleep_ctrl_chk scr_sleep_ctrl_chk_inst (.i_clk(i_clk), .i_srst(i_srst),
  .i_rx_byte_valid(i_rx_byte_valid), .i_rx_fifo_full(i_rx_fifo_full),
  .i_frame_valid(i_frame_valid), .i_frame_b0(i_frame_b0), .o_inhibit_out(o_inhibit_out),
  .o_wake_busy(o_wake_busy), .o_host_data_out(o_host_data_out), .o_wake_tx_en(o_wake_tx_en),
  .o_sense_en(o_sense_en), .o_analog_en(o_analog_en), .o_soft_reset(o_soft_reset),
  .o_rx_fifo_clear(o_rx_fifo_clear), .o_rx_overflow(o_rx_overflow),
  .o_reply_valid(o_reply_valid), .o_reply_id(o_reply_id), .o_reply_dlc(o_reply_dlc));

//--- scr_modem_model.sv
`timescale 1ns/1ps
// ***************
// remote broadcast seen by the modem
// ***************
module scr_modem_model #(
  parameter RX_CYC = 5
)(
  input wire i_clk,
  input wire i_go,
  output reg o_wake_detect = 1'b0,
  output reg o_wake_rx_active = 1'b0
);
  integer cnt_reg = 0;
  // updates on the rising edge by nba, so the design sees it one edge later
  always @(posedge i_clk)
  begin
    o_wake_detect <= i_go;
    o_wake_rx_active <= i_go || cnt_reg > 1;
    cnt_reg <= i_go ? RX_CYC : (cnt_reg > 0 ? cnt_reg - 1 : 0);
  end
endmodule // scr_modem_model

//--- tb_scr_sleep_ctrl.sv
`timescale 1ns/1ps
`include "scr_defs.vh"
module tb_scr_sleep_ctrl;
  localparam [47:0] UID = 48'h0123456789ab; // arbitrary value
  localparam [47:0] CFGS = {8'h09, 8'h0d, 8'h08, 8'h0e, 8'h01, 8'h0f};
  localparam [47:0] LENS = {8'd8, 8'd12, 8'd16, 8'd20, 8'd0, 8'd20};
  reg clk = 0, srst = 1, req_n = 1, cs = 0, rxv = 0, full = 0, fv = 0, go = 0;
  reg [7:0] b0 = 0, b1 = 0, b2 = 0, d, c;
  reg [10:0] fid = 0;
  reg [3:0] dlc = 0;
  wire inhibit_out, busy, host_data_out, wtx, sns, ana, srs, fcl, drv, lvl, ovf, rpv, det, rxa;
  wire [7:0] car, rpd;
  wire [10:0] rid;
  wire [3:0] rdl;
  wire [9:0] thr;
  integer errors = 0, checks = 0, seed = 11, cyc = 0, i, n;
  reg [7:0] m1 = 8'h08, m2 = 8'h50, m3 = 8'h0c, m5 = 8'h00, m6 = 8'h01;
  always #5 clk = ~clk;
  scr_sleep_ctrl #(.PERIOD_CYC(50), .SENSE_CYC(10), .WF_SHORT_CYC(8), .WF_LONG_CYC(12),
    .WP_SHORT_CYC(16), .WP_LONG_CYC(20), .UNIQUE_DEVICE_ID(UID)) scr_sleep_ctrl_inst (
    .i_clk(clk), .i_srst(srst), .i_sleep_request_n(req_n), .i_host_command_select(cs),
    .i_wake_detect(det), .i_wake_rx_active(rxa), .i_rx_byte_valid(rxv), .i_rx_fifo_full(full),
    .i_frame_valid(fv), .i_frame_id(fid), .i_frame_dlc(dlc), .i_frame_b0(b0),
    .i_frame_b1(b1), .i_frame_b2(b2), .o_inhibit_out(inhibit_out), .o_wake_busy(busy),
    .o_host_data_out(host_data_out), .o_wake_tx_en(wtx), .o_sense_en(sns), .o_analog_en(ana),
    .o_soft_reset(srs), .o_rx_fifo_clear(fcl), .o_tx_high_drive(drv), .o_tx_level_2vpp(lvl),
    .o_carrier_sel(car), .o_rx_almost_full_thr(thr), .o_rx_overflow(ovf),
    .o_reply_valid(rpv), .o_reply_id(rid), .o_reply_dlc(rdl), .o_reply_data(rpd));
  scr_modem_model scr_modem_model_inst (.i_clk(clk), .i_go(go), .o_wake_detect(det),
    .o_wake_rx_active(rxa));
  // ***************
  // tasks
  // ***************
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task frm(input [10:0] id, input [3:0] l, input [7:0] x, input [7:0] a, input [7:0] v);
    begin
      @(negedge clk);
      {fid, dlc, b0, b1, b2} = {id, l, x, a, v};
      fv = 1;
      @(negedge clk);
      fv = 0;
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      frm(`SCR_CMD_ID, `SCR_WR_DLC, `SCR_WR_OP, a, v);
      case (a)
        8'h01: m1 = v & 8'h09;
        8'h02: m2 = v;
        8'h03: m3 = v & 8'h0f;
        8'h05: m5 = v;
        8'h06: m6 = v & 8'h03;
      endcase
    end
  endtask
  function [7:0] ev(input [7:0] a);
    case (a)
      8'h01: ev = 8'hf0 | m1;
      8'h02: ev = m2;
      8'h03: ev = 8'h20 | m3;
      8'h05: ev = m5;
      8'h06: ev = m6;
      8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e: ev = UID >> ((8'h5e - a) * 8);
      default: ev = 8'h00;
    endcase
  endfunction
  task rd(input [7:0] a);
    begin
      frm(`SCR_CMD_ID, `SCR_RD_DLC, `SCR_RD_OP, a, 8'h00);
      for (n = 0; rpv !== 1'b1 && n < 3; n = n + 1)
        @(negedge clk);
      chk({rpv, rid, rdl, rpd}, {1'b1, `SCR_RPL_ID, `SCR_RPL_DLC, ev(a)});
    end
  endtask
  task wt(input v);
    for (n = 0; sns !== v && n < 80; n = n + 1)
      @(negedge clk);
  endtask
  // ***************
  // hang guard
  // ***************
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 8000)
    begin
      errors = errors + 1;
      close_out;
    end
  end
  // ***************
  // main sequence
  // ***************
  initial
  begin
    repeat (12) @(negedge clk);
    srst = 0;
    repeat (3) @(negedge clk);
    for (i = 0; i < 96; i = i + 1)
      rd(i[7:0]);
    chk({drv, lvl, car, thr}, {1'b0, 1'b1, 8'h50, 10'h100});
    // bit 7 of 0x03 kept clear here, it would send the block to sleep
    for (i = 0; i < 96; i = i + 1)
    begin
      d = $random(seed);
      if (i == 3)
        d[7] = 1'b0;
      wr(i[7:0], d);
    end
    frm(11'h554, `SCR_WR_DLC, `SCR_WR_OP, 8'h02, ~m2);
    for (i = 0; i < 96; i = i + 1)
      rd(i[7:0]);
    chk({drv, lvl, car, thr}, {m1[0], m1[3], m2, m6[1:0], m5});
    cs = 1;
    repeat (3) @(negedge clk);
    // random pushes and full levels, never together, must leave the flag clear
    for (i = 0; i < 20; i = i + 1)
    begin
      d = $random(seed);
      rxv = d[0];
      full = d[1] & ~d[0];
      @(negedge clk);
    end
    chk(ovf, 0);
    {rxv, full} = 2'b11;
    @(negedge clk);
    rxv = 0;
    chk(ovf, 1);
    cs = 0;
    repeat (4) @(negedge clk);
    chk({ovf, fcl, srs}, 3'b011);
    wr(3, 8'h8b);
    repeat (4) @(negedge clk);
    chk({inhibit_out, ana, host_data_out, srs, sns}, 5'b00010);
    cs = 1;
    repeat (3) @(negedge clk);
    cs = 0;
    repeat (3) @(negedge clk);
    cs = 1;
    repeat (4) @(negedge clk);
    chk({inhibit_out, srs, wtx}, 3'b100);
    cs = 0;
    repeat (3) @(negedge clk);
    rd(3);
    for (i = 0; i < 6; i = i + 1)
    begin
      cs = 0;
      c = CFGS[8 * (5 - i) +: 8];
      repeat (3) @(negedge clk);
      wr(3, c);
      cs = 1;
      repeat (3) @(negedge clk);
      req_n = 0;
      repeat (6) @(negedge clk);
      chk({inhibit_out, sns, ana}, {1'b0, c[1:0] == 2'h1, c[1:0] != 2'h3});
      req_n = 1;
      for (n = 0; wtx !== 1'b1 && n < 10; n = n + 1)
        @(negedge clk);
      for (n = 0; wtx === 1'b1 && n < 40; n = n + 1)
        @(negedge clk);
      chk(n, LENS[8 * (5 - i) +: 8]);
      chk({host_data_out, inhibit_out, srs}, 3'b110);
    end
    cs = 0;
    repeat (3) @(negedge clk);
    wr(3, 8'h04);
    cs = 1;
    repeat (3) @(negedge clk);
    req_n = 0;
    wt(1);
    wt(0);
    chk({inhibit_out, sns}, 2'b00);
    wt(1);
    go = 1;
    @(negedge clk);
    go = 0;
    @(negedge clk);
    chk({inhibit_out, busy, srs}, 3'b111);
    repeat (7) @(negedge clk);
    chk({busy, srs}, 2'b01);
    req_n = 1; // host brings the woken node up
    repeat (4) @(negedge clk);
    chk({inhibit_out, srs}, 2'b10);
    close_out;
  end
endmodule // tb_scr_sleep_ctrl
